// file: common/standby_reset_pkg.sv
// Purpose: constants and carriers for the standby and reset controller
// Assumes: 50 MHz mclk_i, register port with one-cycle read latency
// Notes:   settling count is a top-level parameter for short simulations
package standby_reset_pkg;

  localparam int MCLK_HZ          = 50_000_000;
  localparam int SETTLE_LONG_EXP  = 17;
  localparam int SETTLE_SHORT_EXP = 15;
  localparam int SETTLE_LONG      = 1 << SETTLE_LONG_EXP;
  localparam int SETTLE_SHORT     = 1 << SETTLE_SHORT_EXP;
  localparam int CNT_W            = 18;

  // register indices on the plain port
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h1;
  localparam logic [3:0] ADDR_IRQ_EN  = 4'h2;
  localparam logic [3:0] ADDR_IRQ_REQ = 4'h3;
  localparam logic [3:0] ADDR_PERIPH  = 4'h4;
  localparam logic [3:0] ADDR_MODE    = 4'h5;

  // control register fields
  localparam int CTRL_MIE     = 0;
  localparam int CTRL_BYPASS  = 1;
  localparam int CTRL_SUBCLK  = 2;
  localparam int CTRL_EXTSCK  = 3;
  localparam int CTRL_TMREXT  = 4;
  localparam int CTRL_WTSUB   = 5;
  localparam int CTRL_W       = 6;

  // irq source positions: 0 ext0, 1 ext1, 2 ext2 test, 3 ext4, 4 interval, 5 others
  localparam int NSRC         = 6;
  localparam int SRC_EXT0     = 0;
  localparam int SRC_INTERVAL = 4;

  localparam logic [3:0] SBS_RESET   = 4'h8;
  localparam logic [7:0] MODULO_RST  = 8'hFF;
  localparam int RBE_BIT             = 6;
  localparam int MBE_BIT             = 7;
  localparam int PCH_W               = 5;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_RUN    = 2'b01,
    ST_HALT   = 2'b11,
    ST_STOP   = 2'b10
  } mode_t;

  typedef struct packed {
    logic main_osc;
    logic cpu_clk;
    logic interval_timer;
    logic adc;
    logic serial;
    logic timers;
    logic watch_timer;
    logic ext_irq0;
  } run_en_t;

  typedef struct packed {
    logic [12:0] pc;
    logic        reg_bank_enable;
    logic        mem_bank_enable;
  } vector_t;

endpackage : standby_reset_pkg

// file: hdl/standby_reset_control.sv
// Purpose: reset merge, settling wait, vector load, standby mode control
// Assumes: cpu pulses stop/halt requests; program bytes 0000H/0001H on inputs
// Notes:   clear pulses act on peripheral registers kept elsewhere
//
// Overview of operation
// - internal reset when external pin low or watchdog requests reset
// - wait fixed settling count of main clocks before code runs
// - program counter high from byte 0000H, low byte from 0001H
// - bank enables taken from bits 6 and 7 of byte 0000H
// - reset in standby holds carry, ram, registers, shift register, buffer
// - reset clears skip and status flags; stack pointer left undefined
// - timers, modes, output enables cleared; modulo registers set to FFH
// - irq request, enable, priority and edge mode registers cleared
// - port buffers off, latches, direction and pull-up settings cleared
// - clock control, clock out, sub oscillator, serial mode registers cleared
// - stop only from main clock; halt from either clock
// - stop halts main oscillator; halt stops the cpu clock and, without filter bypass, ext irq0
// - interval timer and adc stop in stop, run in halt with main osc
// - serial runs in stop only with external clock; halt also main osc
// - timers count in standby on external or sub clock watch source
// - watch timer runs in stop only from sub clock; always in halt
// - ext irqs 1,2,4 active in standby; irq0 only with filter bypass
// - filtered irq0 never releases standby
// - standby released by enabled irq, enabled test request, or reset
// - acceptance needs source enable and master enable; requests readable
`timescale 1ns/10ps
module standby_reset_control #(
  parameter int SETTLE_CYCLES = standby_reset_pkg::SETTLE_LONG
) (
  input  wire logic                                  mclk_i,
  input  wire logic                                  rst_b_i,
  input  wire logic                                  ext_reset_b_i,
  input  wire logic                                  wdt_reset_i,
  input  wire logic [7:0]                            rom_byte0_i,
  input  wire logic [7:0]                            rom_byte1_i,
  input  wire logic                                  stop_req_i,
  input  wire logic                                  halt_req_i,
  input  wire logic [standby_reset_pkg::NSRC-1:0]    irq_event_i,
  input  wire logic [3:0]                            addr_i,
  input  wire logic [7:0]                            wdata_i,
  input  wire logic                                  wr_i,
  input  wire logic                                  rd_i,
  output logic [7:0]                                 rdata_o,
  output logic                                       int_reset_o,
  output logic                                       cpu_run_o,
  output standby_reset_pkg::vector_t                 vector_o,
  output standby_reset_pkg::run_en_t                 run_en_o,
  output logic                                       hold_state_o,
  output logic                                       periph_clear_o,
  output logic [3:0]                                 stack_bank_select_o,
  output logic [3:0]                                 mem_bank_select_o,
  output logic [1:0]                                 reg_bank_select_o,
  output logic [2:0]                                 skip_flags_o,
  output logic [1:0]                                 irq_status_o,
  output logic [7:0]                                 timer0_modulo_o,
  output logic [7:0]                                 timer1_modulo_o,
  output logic                                       irq_accept_o
);

  localparam int NSRC  = standby_reset_pkg::NSRC;
  localparam int CNT_W = standby_reset_pkg::CNT_W;

  // synchronisers for pins
  logic ext_b_s1_reg, ext_b_s2_reg;
  logic wdt_s1_reg, wdt_s2_reg;
  logic [NSRC-1:0] ev_s1_reg, ev_s2_reg;

  // internal reset source, asynchronous on all three inputs
  logic src_rst_b;
  assign src_rst_b = rst_b_i & ext_reset_b_i & ~wdt_reset_i;

  logic rst_s1_reg, rst_s2_reg;
  always_ff @(posedge mclk_i or negedge src_rst_b) begin
    if (!src_rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_b_s1_reg <= 1'b1;
      ext_b_s2_reg <= 1'b1;
      wdt_s1_reg   <= 1'b0;
      wdt_s2_reg   <= 1'b0;
      ev_s1_reg    <= '0;
      ev_s2_reg    <= '0;
    end else begin
      ext_b_s1_reg <= ext_reset_b_i;
      ext_b_s2_reg <= ext_b_s1_reg;
      wdt_s1_reg   <= wdt_reset_i;
      wdt_s2_reg   <= wdt_s1_reg;
      ev_s1_reg    <= irq_event_i;
      ev_s2_reg    <= ev_s1_reg;
    end
  end

  // mode state machine
  standby_reset_pkg::mode_t mode_reg, mode_next;
  logic [standby_reset_pkg::CNT_W-1:0] settle_reg;
  logic [standby_reset_pkg::CTRL_W-1:0] ctrl_reg;
  logic [NSRC-1:0] irq_en_reg, irq_req_reg;
  logic in_standby_reg;
  logic release_req;
  logic settle_done;

  assign settle_done = (settle_reg == CNT_W'(SETTLE_CYCLES - 1));

  // release sources: irq0 only when filter bypassed
  logic [NSRC-1:0] release_mask;
  always_comb begin
    release_mask = irq_en_reg;
    if (!ctrl_reg[standby_reset_pkg::CTRL_BYPASS]) begin
      release_mask[standby_reset_pkg::SRC_EXT0] = 1'b0;
    end
  end
  assign release_req = |(irq_req_reg & release_mask);

  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      standby_reset_pkg::ST_SETTLE: begin
        if (settle_done) begin
          mode_next = standby_reset_pkg::ST_RUN;
        end
      end
      standby_reset_pkg::ST_RUN: begin
        if (stop_req_i && !ctrl_reg[standby_reset_pkg::CTRL_SUBCLK]) begin
          mode_next = standby_reset_pkg::ST_STOP;
        end else if (halt_req_i) begin
          mode_next = standby_reset_pkg::ST_HALT;
        end
      end
      standby_reset_pkg::ST_HALT: begin
        if (release_req) begin
          mode_next = standby_reset_pkg::ST_RUN;
        end
      end
      standby_reset_pkg::ST_STOP: begin
        if (release_req) begin
          mode_next = standby_reset_pkg::ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      mode_reg <= standby_reset_pkg::ST_SETTLE;
    end else begin
      mode_reg <= mode_next;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      settle_reg <= '0;
    end else if (mode_reg == standby_reset_pkg::ST_SETTLE && !settle_done) begin
      settle_reg <= settle_reg + 1'b1;
    end
  end

  // standby memory survives a reset; plain power reset clears it
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      in_standby_reg <= 1'b0;
      hold_state_o   <= 1'b0;
    end else begin
      if (!rst_s2_reg) begin
        hold_state_o <= hold_state_o | in_standby_reg;
      end else if (mode_reg == standby_reset_pkg::ST_RUN) begin
        hold_state_o <= 1'b0;
      end
      in_standby_reg <= rst_s2_reg &&
        (mode_reg == standby_reset_pkg::ST_HALT || mode_reg == standby_reset_pkg::ST_STOP);
    end
  end

  // reset-state outputs and vector
  always_ff @(posedge mclk_i or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      int_reset_o         <= 1'b1;
      periph_clear_o      <= 1'b1;
      stack_bank_select_o <= standby_reset_pkg::SBS_RESET;
      mem_bank_select_o   <= 4'h0;
      reg_bank_select_o   <= 2'h0;
      skip_flags_o        <= 3'h0;
      irq_status_o        <= 2'h0;
      timer0_modulo_o     <= standby_reset_pkg::MODULO_RST;
      timer1_modulo_o     <= standby_reset_pkg::MODULO_RST;
      vector_o            <= '0;
    end else begin
      int_reset_o    <= (mode_reg == standby_reset_pkg::ST_SETTLE) && !settle_done;
      periph_clear_o <= (mode_reg == standby_reset_pkg::ST_SETTLE) && !settle_done;
      if (mode_reg == standby_reset_pkg::ST_SETTLE) begin
        vector_o.pc <= {rom_byte0_i[standby_reset_pkg::PCH_W-1:0], rom_byte1_i};
        vector_o.reg_bank_enable <= rom_byte0_i[standby_reset_pkg::RBE_BIT];
        vector_o.mem_bank_enable <= rom_byte0_i[standby_reset_pkg::MBE_BIT];
      end
    end
  end

  // register port; all control cleared by internal reset
  always_ff @(posedge mclk_i or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      ctrl_reg   <= '0;
      irq_en_reg <= '0;
    end else if (wr_i) begin
      if (addr_i == standby_reset_pkg::ADDR_CTRL) begin
        ctrl_reg <= wdata_i[standby_reset_pkg::CTRL_W-1:0];
      end
      if (addr_i == standby_reset_pkg::ADDR_IRQ_EN) begin
        irq_en_reg <= wdata_i[NSRC-1:0];
      end
    end
  end

  // sticky requests; set wins over write-one-to-clear
  logic [NSRC-1:0] src_live;
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_req
      if (g == standby_reset_pkg::SRC_EXT0) begin : g_ext0
        assign src_live[g] = !in_standby_reg ||
          ctrl_reg[standby_reset_pkg::CTRL_BYPASS];
      end else if (g == standby_reset_pkg::SRC_INTERVAL) begin : g_bt
        assign src_live[g] = mode_reg != standby_reset_pkg::ST_STOP;
      end else begin : g_other
        assign src_live[g] = 1'b1;
      end
      always_ff @(posedge mclk_i or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
          irq_req_reg[g] <= 1'b0;
        end else if (ev_s2_reg[g] && src_live[g]) begin
          irq_req_reg[g] <= 1'b1;
        end else if (wr_i && addr_i == standby_reset_pkg::ADDR_IRQ_REQ && wdata_i[g]) begin
          irq_req_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      irq_accept_o <= 1'b0;
    end else begin
      irq_accept_o <= ctrl_reg[standby_reset_pkg::CTRL_MIE] &&
        |(irq_req_reg & irq_en_reg);
    end
  end

  // peripheral run enables per mode
  standby_reset_pkg::run_en_t run_next;
  logic main_osc_on;
  always_comb begin
    main_osc_on = mode_reg != standby_reset_pkg::ST_STOP;
    run_next.main_osc       = main_osc_on;
    run_next.cpu_clk        = mode_reg == standby_reset_pkg::ST_RUN;
    run_next.interval_timer = main_osc_on;
    run_next.adc            = main_osc_on;
    run_next.serial         = main_osc_on || ctrl_reg[standby_reset_pkg::CTRL_EXTSCK];
    run_next.timers         = main_osc_on || ctrl_reg[standby_reset_pkg::CTRL_TMREXT];
    run_next.watch_timer    = main_osc_on || ctrl_reg[standby_reset_pkg::CTRL_WTSUB];
    run_next.ext_irq0       = mode_reg == standby_reset_pkg::ST_RUN ||
                              ctrl_reg[standby_reset_pkg::CTRL_BYPASS];
  end

  always_ff @(posedge mclk_i or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      run_en_o  <= '0;
      cpu_run_o <= 1'b0;
    end else begin
      run_en_o  <= run_next;
      cpu_run_o <= mode_next == standby_reset_pkg::ST_RUN;
    end
  end

  // read data one cycle later
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        standby_reset_pkg::ADDR_CTRL:    rdata_o <= 8'(ctrl_reg);
        standby_reset_pkg::ADDR_STATUS:  rdata_o <= {5'h00, hold_state_o, 2'(mode_reg)};
        standby_reset_pkg::ADDR_IRQ_EN:  rdata_o <= 8'(irq_en_reg);
        standby_reset_pkg::ADDR_IRQ_REQ: rdata_o <= 8'(irq_req_reg);
        standby_reset_pkg::ADDR_PERIPH:  rdata_o <= 8'(run_en_o);
        standby_reset_pkg::ADDR_MODE:    rdata_o <= {7'h00, ext_b_s2_reg ^ wdt_s2_reg};
        default:                         rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  stop_main_osc_a: assert property (@(posedge mclk_i) disable iff (!rst_s2_reg)
    mode_reg == standby_reset_pkg::ST_STOP |=> !run_en_o.main_osc && !run_en_o.adc)
    else $error("main oscillator running in stop");
  stop_from_sub_a: assert property (@(posedge mclk_i) disable iff (!rst_s2_reg)
    (mode_reg == standby_reset_pkg::ST_RUN && ctrl_reg[standby_reset_pkg::CTRL_SUBCLK])
    |=> mode_reg != standby_reset_pkg::ST_STOP)
    else $error("stop entered on sub clock");
  filtered_no_release_a: assert property (@(posedge mclk_i) disable iff (!rst_s2_reg)
    (mode_reg == standby_reset_pkg::ST_STOP && !release_req) |=>
    mode_reg == standby_reset_pkg::ST_STOP)
    else $error("standby left without release");
  release_wake_a: assert property (@(posedge mclk_i) disable iff (!rst_s2_reg)
    (mode_reg == standby_reset_pkg::ST_HALT && release_req) |=>
    mode_reg == standby_reset_pkg::ST_RUN && cpu_run_o)
    else $error("enabled request did not release halt");
  accept_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_s2_reg)
    irq_accept_o |-> $past(ctrl_reg[standby_reset_pkg::CTRL_MIE]))
    else $error("irq accepted without master enable");
  settle_wait_a: assert property (@(posedge mclk_i) disable iff (!rst_s2_reg)
    (mode_reg == standby_reset_pkg::ST_SETTLE && !settle_done) |=>
    !cpu_run_o && int_reset_o)
    else $error("code ran before settling");
  halt_cpu_stop_a: assert property (@(posedge mclk_i) disable iff (!rst_s2_reg)
    mode_reg == standby_reset_pkg::ST_HALT |=> !run_en_o.cpu_clk && run_en_o.main_osc)
    else $error("halt enables wrong");
  vector_load_a: assert property (@(posedge mclk_i) disable iff (!rst_s2_reg)
    mode_reg == standby_reset_pkg::ST_SETTLE |=>
    vector_o.mem_bank_enable == $past(rom_byte0_i[standby_reset_pkg::MBE_BIT]))
    else $error("bank enable not loaded");
  serial_stop_a: assert property (@(posedge mclk_i) disable iff (!rst_s2_reg)
    mode_reg == standby_reset_pkg::ST_STOP |=>
    run_en_o.serial == $past(ctrl_reg[standby_reset_pkg::CTRL_EXTSCK]))
    else $error("serial enable wrong in stop");
  timer_stop_a: assert property (@(posedge mclk_i) disable iff (!rst_s2_reg)
    mode_reg == standby_reset_pkg::ST_STOP |=>
    run_en_o.timers == $past(ctrl_reg[standby_reset_pkg::CTRL_TMREXT]))
    else $error("timer enable wrong in stop");
  watch_stop_a: assert property (@(posedge mclk_i) disable iff (!rst_s2_reg)
    mode_reg == standby_reset_pkg::ST_STOP |=>
    run_en_o.watch_timer == $past(ctrl_reg[standby_reset_pkg::CTRL_WTSUB]))
    else $error("watch timer enable wrong in stop");

endmodule : standby_reset_control

// file: testbench/reset_event_source.sv
// Purpose: far side model: reset pin, watchdog request and event sources
// Assumes: changes only just after mclk_i rising edges
// Notes:   every source returns to idle after its pulse
`timescale 1ns/10ps
module reset_event_source (
  input  wire logic                               mclk_i,
  output logic                                    ext_reset_b_o,
  output logic                                    wdt_reset_o,
  output logic [standby_reset_pkg::NSRC-1:0]      irq_event_o
);
  initial begin
    ext_reset_b_o = 1'b1;
    wdt_reset_o   = 1'b0;
    irq_event_o   = '0;
  end

  // src 0..5 event bit, 6 reset pin, 7 watchdog; held n cycles
  task automatic pulse(input int src, input int n);
    @(posedge mclk_i);
    case (src)
      6: ext_reset_b_o <= 1'b0;
      7: wdt_reset_o <= 1'b1;
      default: irq_event_o[src] <= 1'b1;
    endcase
    repeat (n) @(posedge mclk_i);
    ext_reset_b_o <= 1'b1;
    wdt_reset_o   <= 1'b0;
    irq_event_o   <= '0;
  endtask : pulse
endmodule : reset_event_source

// file: testbench/tb_standby_reset_control.sv
// Purpose: self-checking bench for the standby and reset controller
// Assumes: short settling count, register port with one-cycle read data
// Notes:   only mismatches and the verdict are printed
`timescale 1ns/10ps
module tb_standby_reset_control;
  localparam int         SETTLE = 16;
  localparam logic [7:0] ROM0   = 8'h95;
  localparam logic [7:0] ROM1   = 8'h3C;

  logic                              mclk_i, rst_b_i, ext_reset_b, wdt_reset;
  logic                              stop_req_i, halt_req_i, wr_i, rd_i;
  logic [standby_reset_pkg::NSRC-1:0] irq_event;
  logic [3:0]                        addr_i, stack_bank_select, mem_bank_select;
  logic [7:0]                        wdata_i, rdata_o, mod0, mod1;
  logic                              int_reset_o, cpu_run_o, hold_o, clr_o, acc_o;
  logic [1:0]                        reg_bank_select, ist;
  logic [2:0]                        skip;
  standby_reset_pkg::vector_t        vec;
  standby_reset_pkg::run_en_t        run_en;
  int                                miscompares, n_checks, cnt;

  standby_reset_control #(.SETTLE_CYCLES(SETTLE)) u_standby_reset_control (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ext_reset_b_i(ext_reset_b),
    .wdt_reset_i(wdt_reset), .rom_byte0_i(ROM0), .rom_byte1_i(ROM1),
    .stop_req_i(stop_req_i), .halt_req_i(halt_req_i), .irq_event_i(irq_event),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .int_reset_o(int_reset_o), .cpu_run_o(cpu_run_o), .vector_o(vec), .run_en_o(run_en),
    .hold_state_o(hold_o), .periph_clear_o(clr_o), .stack_bank_select_o(stack_bank_select),
    .mem_bank_select_o(mem_bank_select), .reg_bank_select_o(reg_bank_select), .skip_flags_o(skip),
    .irq_status_o(ist), .timer0_modulo_o(mod0), .timer1_modulo_o(mod1),
    .irq_accept_o(acc_o));

  reset_event_source u_reset_event_source (
    .mclk_i(mclk_i), .ext_reset_b_o(ext_reset_b), .wdt_reset_o(wdt_reset),
    .irq_event_o(irq_event));

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    check(what, rdata_o, exp);
  endtask : rd

  task automatic req(input bit stop);
    @(posedge mclk_i);
    if (stop) stop_req_i <= 1'b1;
    else halt_req_i <= 1'b1;
    @(posedge mclk_i);
    stop_req_i <= 1'b0;
    halt_req_i <= 1'b0;
  endtask : req

  // bounded wait for cpu_run_o to reach a level
  task automatic wait_run(input bit want, input int max, input string what);
    int k;
    k = 0;
    while (cpu_run_o !== want && k < max) begin
      @(posedge mclk_i);
      #1;
      k++;
    end
    check(what, cpu_run_o, want);
  endtask : wait_run

  task automatic end_of_test();
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20000) @(posedge mclk_i);
    miscompares++;
    end_of_test();
  end

  initial begin
    miscompares = 0;
    n_checks    = 0;
    rst_b_i     = 1'b0;
    stop_req_i  = 1'b0;
    halt_req_i  = 1'b0;
    wr_i        = 1'b0;
    rd_i        = 1'b0;
    addr_i      = 4'h0;
    wdata_i     = 8'h00;
    repeat (5) @(posedge mclk_i);
    check("sbs", stack_bank_select, 4'h8);
    check("mbs rbs", {mem_bank_select, reg_bank_select}, 6'h00);
    check("skip status", {skip, ist}, 5'h00);
    check("modulo", {mod0, mod1}, 16'hFFFF);
    check("clear", {clr_o, int_reset_o, cpu_run_o}, 3'b110);
    check("run_en", run_en, 8'h00);
    rst_b_i <= 1'b1;
    cnt = 0;
    while (int_reset_o !== 1'b0 && cnt < 100) begin
      @(posedge mclk_i);
      cnt++;
    end
    check("settle", (cnt >= SETTLE && cnt <= SETTLE + 4), 1'b1);
    wait_run(1'b1, 8, "run");
    check("vector", vec, {ROM0[4:0], ROM1, ROM0[6], ROM0[7]});
    check("bank en", {vec.reg_bank_enable, vec.mem_bank_enable}, 2'b01);
    check("hold", hold_o, 1'b0);
    check("clear off", clr_o, 1'b0);
    rd(4'h1, 8'h01, "status run");
    rd(4'hF, 8'h00, "unmapped");
    wr(4'h2, 8'h02);
    req(1'b0);
    wait_run(1'b0, 4, "halt");
    rd(4'h1, 8'h03, "status halt");
    check("run_en halt", run_en, 8'hBE);
    u_reset_event_source.pulse(1, 3);
    wait_run(1'b1, 10, "halt release");
    rd(4'h3, 8'h02, "req poll");
    wr(4'h3, 8'h02);
    rd(4'h3, 8'h00, "req clear");
    wr(4'h0, 8'h01);
    u_reset_event_source.pulse(1, 3);
    repeat (4) @(posedge mclk_i);
    check("accept", acc_o, 1'b1);
    wr(4'h2, 8'h00);
    repeat (2) @(posedge mclk_i);
    check("accept off", acc_o, 1'b0);
    wr(4'h3, 8'h02);
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h03);
    req(1'b1);
    wait_run(1'b0, 4, "stop");
    rd(4'h1, 8'h02, "status stop");
    check("run_en stop", run_en, 8'h00);
    u_reset_event_source.pulse(0, 3);
    repeat (8) @(posedge mclk_i);
    check("filtered irq0", cpu_run_o, 1'b0);
    u_reset_event_source.pulse(1, 3);
    wait_run(1'b1, 10, "stop release");
    wr(4'h3, 8'h03);
    wr(4'h0, 8'h04);
    req(1'b1);
    repeat (3) @(posedge mclk_i);
    check("stop on sub clock", cpu_run_o, 1'b1);
    req(1'b0);
    wait_run(1'b0, 4, "halt sub");
    u_reset_event_source.pulse(1, 3);
    wait_run(1'b1, 10, "halt sub release");
    wr(4'h3, 8'h03);
    wr(4'h0, 8'h3A);
    req(1'b1);
    wait_run(1'b0, 4, "stop opts");
    check("run_en opts", run_en, 8'h0F);
    u_reset_event_source.pulse(0, 3);
    wait_run(1'b1, 10, "irq0 bypass");
    wr(4'h3, 8'h03);
    req(1'b1);
    wait_run(1'b0, 4, "stop again");
    u_reset_event_source.pulse(6, 3);
    check("pin reset", int_reset_o, 1'b1);
    rd(4'h1, 8'h04, "status hold");
    wait_run(1'b1, 40, "after pin reset");
    check("hold standby", hold_o, 1'b1);
    rd(4'h2, 8'h00, "irq en cleared");
    rd(4'h0, 8'h00, "ctrl cleared");
    u_reset_event_source.pulse(7, 2);
    check("wdt reset", int_reset_o, 1'b1);
    rd(4'h1, 8'h00, "status no hold");
    wait_run(1'b1, 40, "after wdt reset");
    check("hold run", hold_o, 1'b0);
    check("sbs again", stack_bank_select, 4'h8);
    end_of_test();
  end
endmodule : tb_standby_reset_control
